/* File: hw/snv_top.sv */
// serial nvram control: serial instruction port, ram, shadow array, save/reload and axi4-lite view
// Summary of operation
// - power-up clears the write enable latch
// - ram writes and saves refused until the set-latch command
// - latch stays set until power-up, clear command, completed save or low supply
// - latch clear: every ram write and save request ignored
// - ram reads work whatever the latch state
// - sleep command: ram lost, shadow array keeps last save
// - a reload request not blocked by a save wakes the device and refills ram
// - reload command or low reload pin copies shadow array into ram
// - automatic reload at power-up
// - no ram write or save before an explicit reload
// - every explicit reload sets the previous-reload latch
// - save command or low save pin copies ram into shadow array
// - save needs both previous-reload and write latches set
// - during a save the serial port and the save and reload pins are inhibited
// - completed save clears the write enable latch
// - low supply blocks saves and clears the write latch
// - read: start, 4 address bits, opcode, then 16 data bits out
// - first read bit after 8th falling edge, rest after rising edges
// - write: start, address, opcode, then 16 data bits stored
// - eight-bit instruction, start bit, address, three-bit opcode
// - input sampled on rising shift clock; output floats unless reading
// - chip select drop aborts instruction and clears shift register
// - save request has priority over a coincident reload or latch command
`timescale 1ns/10ps
`include "snv_regs.svh"
module snv_top
  import snv_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = `SNV_STORE_TIME_NS / `SNV_CLK_PERIOD_NS,
  parameter int unsigned WORDS = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic chip_select,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic save_pin_n,
  input wire logic reload_pin_n,
  input wire logic supply_low,
  output logic store_busy
);
  localparam int AW = $clog2(WORDS);
  localparam logic [5:0] PIN_RST = 6'h30; // active-low save/reload pins idle high
  logic [5:0] pin_raw, pin_meta, pin_sync;
  logic shclk_d, save_pin_d, reload_pin_d, shclk_rise, shclk_fall;
  logic [15:0] ram [WORDS];
  logic [15:0] nv [WORDS];
  snv_status_s st;
  snv_cmd_s cmd;
  snv_ser_e ser;
  logic [6:0] shreg;
  logic [4:0] bit_cnt;
  logic [15:0] word_sr;
  logic [AW-1:0] cmd_addr;
  logic [31:0] store_cnt;
  logic rd_pending, pwr_pend, restart_req;
  logic save_req, save_go, reload_go, ram_wr_ok;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [AW:0] ri, ni;
  // decodes an instruction opcode as a read (11x)
  function automatic logic is_read(input logic [2:0] op);
    is_read = (op[2:1] == 2'h3);
  endfunction

  // maps a byte address into a word window, valid flag in the top bit
  function automatic logic [AW:0] win_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    win_idx = {(a >= base) && (off < 8'(WORDS * 4)) && (off[1:0] == 2'h0), off[AW+1:2]};
  endfunction
  // all pins in one vector for the synchronisers
  assign pin_raw = {reload_pin_n, save_pin_n, supply_low, serial_in, shift_clock, chip_select};
  // two-flop synchronisers for every pin
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_meta[gi] <= PIN_RST[gi];
          pin_sync[gi] <= PIN_RST[gi];
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate
  // edge history on the synchronised side only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shclk_d <= 1'b0;
      save_pin_d <= 1'b1;
      reload_pin_d <= 1'b1;
    end else begin
      shclk_d <= pin_sync[1];
      save_pin_d <= pin_sync[4];
      reload_pin_d <= pin_sync[5];
    end
  end
  // one-cycle strobes on the synchronised shift clock
  assign shclk_rise = pin_sync[1] & ~shclk_d;
  assign shclk_fall = ~pin_sync[1] & shclk_d;
  // serial front end; ignores the link while a save runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser <= SNV_IDLE;
      shreg <= 7'h00;
      bit_cnt <= 5'h00;
      word_sr <= 16'h0000;
      cmd_addr <= '0;
      rd_pending <= 1'b0;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
      cmd <= '0;
    end else begin
      cmd <= '0;
      if (!pin_sync[0]) begin
        ser <= SNV_IDLE;
        shreg <= 7'h00;
        bit_cnt <= 5'h00;
        rd_pending <= 1'b0;
        serial_out_oe <= 1'b0;
      end else if (st.store_busy) begin
        ser <= SNV_DONE;
      end else begin
        case (ser)
          SNV_IDLE: begin
            if (shclk_rise && pin_sync[2]) begin
              ser <= SNV_INSTR;
              bit_cnt <= 5'h00;
            end
          end
          SNV_INSTR: begin
            if (shclk_rise) begin
              shreg <= {shreg[5:0], pin_sync[2]};
              bit_cnt <= bit_cnt + 5'h01;
              // address then opcode after the start bit
              if (bit_cnt == 5'(`SNV_INST_BITS - 1)) begin
                cmd_addr <= shreg[2 +: AW];
                bit_cnt <= 5'h00;
                ser <= SNV_DONE;
                if (is_read({shreg[1:0], pin_sync[2]})) begin
                  // reads never look at the latch
                  word_sr <= st.sleeping ? 16'h0000 : ram[shreg[2 +: AW]];
                  rd_pending <= 1'b1;
                  ser <= SNV_RDATA;
                end else begin
                  case ({shreg[1:0], pin_sync[2]})
                    `SNV_OP_CLR_LATCH: cmd.clr_latch <= 1'b1;
                    `SNV_OP_SAVE: cmd.save <= 1'b1;
                    `SNV_OP_SLEEP: cmd.sleep <= 1'b1;
                    `SNV_OP_WRITE: ser <= SNV_WDATA;
                    `SNV_OP_SET_LATCH: cmd.set_latch <= 1'b1;
                    `SNV_OP_RELOAD: cmd.reload <= 1'b1;
                    default: ser <= SNV_DONE;
                  endcase
                end
              end
            end
          end
          SNV_WDATA: begin
            // sixteen data bits, first bit is bit 0
            if (shclk_rise) begin
              word_sr <= {pin_sync[2], word_sr[15:1]};
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == 5'(`SNV_WORD_BITS - 1)) begin
                cmd.write <= 1'b1;
                ser <= SNV_DONE;
              end
            end
          end
          SNV_RDATA: begin
            // bit 0 on the 8th falling edge, then rising edges
            if (shclk_fall && rd_pending) begin
              rd_pending <= 1'b0;
              serial_out <= word_sr[0];
              serial_out_oe <= 1'b1;
            end else if (shclk_rise && !rd_pending) begin
              if (bit_cnt == 5'(`SNV_WORD_BITS - 1)) begin
                // float again after the last bit
                serial_out_oe <= 1'b0;
                ser <= SNV_DONE;
              end else begin
                bit_cnt <= bit_cnt + 5'h01;
                word_sr <= {1'b0, word_sr[15:1]};
                serial_out <= word_sr[1];
              end
            end
          end
          SNV_DONE: ser <= SNV_DONE; // wait for deselect
          default: ser <= SNV_IDLE;
        endcase
      end
    end
  end
  // request arbitration; pins act on their falling edge only
  assign save_req = cmd.save | (save_pin_d & ~pin_sync[4]);
  assign save_go = save_req && !st.store_busy && st.write_latch && st.prev_recall && !pin_sync[3];
  // save wins over a coincident reload
  assign reload_go = !st.store_busy && !save_go && (cmd.reload || (reload_pin_d && !pin_sync[5]));
  // write only with the latch set
  assign ram_wr_ok = cmd.write && st.write_latch && st.prev_recall && !st.sleeping && !st.store_busy;
  // power-up event: after reset release, or on software restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_pend <= 1'b1;
    end else begin
      pwr_pend <= restart_req;
    end
  end
  // latches and save sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      store_cnt <= 32'h0000_0000;
    end else begin
      st.low_supply <= pin_sync[3];
      if (pwr_pend) begin
        // automatic reload, latches as at power-up
        st.write_latch <= 1'b0;
        st.prev_recall <= 1'b0;
        st.sleeping <= 1'b0;
        st.store_busy <= 1'b0;
      end else if (st.store_busy) begin
        // busy stands until done or aborted
        store_cnt <= store_cnt + 32'h0000_0001;
        if (pin_sync[3]) begin
          st.store_busy <= 1'b0;
        end else if (store_cnt >= STORE_CYCLES - 1) begin
          st.store_busy <= 1'b0;
          st.write_latch <= 1'b0;
        end
      end else if (save_go) begin
        // start copying ram into the shadow array
        st.store_busy <= 1'b1;
        store_cnt <= 32'h0000_0000;
      end else begin
        if (reload_go) begin
          st.sleeping <= 1'b0;
          st.prev_recall <= 1'b1;
        end else if (cmd.sleep) begin
          st.sleeping <= 1'b1;
        end
        // only the set command opens the latch
        // held until clear command, save, low supply or power-up
        if (cmd.set_latch) begin
          st.write_latch <= 1'b1;
        end else if (cmd.clr_latch) begin
          st.write_latch <= 1'b0;
        end
      end
      // low supply drops the latch, overriding a set
      if (pin_sync[3]) begin
        st.write_latch <= 1'b0;
      end
    end
  end
  // busy level straight from the status flag
  assign store_busy = st.store_busy;
  // ram contents; no reset, nothing survives sleep anyway
  always_ff @(posedge aclk) begin
    if (pwr_pend || reload_go) begin
      // whole shadow array copied into ram
      for (int i = 0; i < WORDS; i++) begin
        ram[i] <= nv[i];
      end
    end else if (cmd.sleep && !st.store_busy) begin
      for (int i = 0; i < WORDS; i++) begin
        ram[i] <= 16'h0000;
      end
    end else if (ram_wr_ok) begin
      ram[cmd_addr] <= word_sr;
    end
  end
  // shadow array; cleared only by the bus reset, models blank cells
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < WORDS; i++) begin
        nv[i] <= 16'h0000;
      end
    end else if (st.store_busy && !pin_sync[3] && store_cnt >= STORE_CYCLES - 1) begin
      // commit at the end of the save time
      for (int i = 0; i < WORDS; i++) begin
        nv[i] <= ram[i];
      end
    end
  end
  // axi write side: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SNV_RESP_OKAY;
      restart_req <= 1'b0;
    end else begin
      restart_req <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `SNV_CTRL_OFS) begin
          s_axi_bresp <= `SNV_RESP_OKAY;
          // restart reruns the power-up sequence
          restart_req <= w_strb[0] & w_data[`SNV_CTRL_RESTART_BIT];
        end else if (aw_addr == `SNV_STATUS_OFS || win_idx(aw_addr, `SNV_RAM_BASE) >> AW != 0
                     || win_idx(aw_addr, `SNV_NV_BASE) >> AW != 0) begin
          s_axi_bresp <= `SNV_RESP_SLVERR; // read-only
        end else begin
          s_axi_bresp <= `SNV_RESP_DECERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // axi read side: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  assign ri = win_idx(s_axi_araddr, `SNV_RAM_BASE);
  assign ni = win_idx(s_axi_araddr, `SNV_NV_BASE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SNV_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SNV_RESP_OKAY;
      if (s_axi_araddr == `SNV_CTRL_OFS) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr == `SNV_STATUS_OFS) begin
        s_axi_rdata <= {27'h0000000, st};
      end else if (ri[AW]) begin
        s_axi_rdata <= {16'h0000, st.sleeping ? 16'h0000 : ram[ri[AW-1:0]]};
      end else if (ni[AW]) begin
        s_axi_rdata <= {16'h0000, nv[ni[AW-1:0]]};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `SNV_RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: hw/snv_regs.svh */
// register offsets, field positions, opcodes and timing figures of the serial nvram control block
`ifndef SNV_REGS_SVH
`define SNV_REGS_SVH
`define SNV_CTRL_OFS 8'h00
`define SNV_STATUS_OFS 8'h04
`define SNV_RAM_BASE 8'h40
`define SNV_NV_BASE 8'h80
`define SNV_CTRL_RESTART_BIT 0
`define SNV_ST_WEL_BIT 0
`define SNV_ST_PREV_BIT 1
`define SNV_ST_BUSY_BIT 2
`define SNV_ST_SLEEP_BIT 3
`define SNV_ST_LOWV_BIT 4
`define SNV_OP_CLR_LATCH 3'h0
`define SNV_OP_SAVE 3'h1
`define SNV_OP_SLEEP 3'h2
`define SNV_OP_WRITE 3'h3
`define SNV_OP_SET_LATCH 3'h4
`define SNV_OP_RELOAD 3'h5
`define SNV_RESP_OKAY 2'h0
`define SNV_RESP_SLVERR 2'h2
`define SNV_RESP_DECERR 2'h3
`define SNV_CLK_PERIOD_NS 5
`define SNV_STORE_TIME_NS 10000000
`define SNV_INST_BITS 7
`define SNV_WORD_BITS 16
`endif

/* File: hw/snv_pkg.sv */
// types shared by the serial nvram control block
package snv_pkg;
  // serial front end states
  typedef enum logic [2:0] {
    SNV_IDLE,
    SNV_INSTR,
    SNV_WDATA,
    SNV_RDATA,
    SNV_DONE
  } snv_ser_e;
  // latched control state shown to software
  typedef struct packed {
    logic low_supply;
    logic sleeping;
    logic store_busy;
    logic prev_recall;
    logic write_latch;
  } snv_status_s;
  // one-cycle command events from the serial decoder
  typedef struct packed {
    logic clr_latch;
    logic set_latch;
    logic save;
    logic sleep;
    logic reload;
    logic write;
  } snv_cmd_s;
endpackage

/* File: tb/snv_top_asserts.sv */
// concurrent checks on the ports of the serial nvram control block
`timescale 1ns/10ps
module snv_top_asserts #(
  parameter int unsigned STORE_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic chip_select,
  input wire logic serial_out_oe,
  input wire logic supply_low,
  input wire logic store_busy
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  int unsigned busy_cnt;
  // length of the running save, so an endless busy is caught
  always_ff @(posedge aclk) begin
    if (!aresetn || !store_busy) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  a_oe_needs_cs: assert property ((!chip_select)[*4] |-> !serial_out_oe)
    else $error("serial output driven while deselected");
  a_lowv_no_save: assert property (supply_low[*6] |-> !store_busy)
    else $error("save running with supply low");
  a_busy_min: assert property ($rose(store_busy) |-> store_busy[*8])
    else $error("save busy dropped too early");
  a_busy_bound: assert property (busy_cnt <= STORE_CYCLES + 4)
    else $error("save busy outlasts the save time");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
endmodule
bind snv_top snv_top_asserts #(.STORE_CYCLES(STORE_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .chip_select(chip_select),
  .serial_out_oe(serial_out_oe), .supply_low(supply_low), .store_busy(store_busy));

/* File: tb/snv_host_model.sv */
// host controller model driving the serial instruction port
`timescale 1ns/10ps
module snv_host_model (
  output logic chip_select,
  output logic shift_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // shift clock stands low outside frames
  initial begin
    chip_select = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end
  // n bits msb first, cs held, data changed after fall
  task automatic frame(input logic [31:0] v, input int n, input int rd, output logic [15:0] q);
    q = 16'h0000;
    chip_select = 1'b1;
    #100;
    for (int k = 1; k <= n + 1; k++) begin
      if (k <= n) serial_in = v[32 - k];
      #30;
      // read bit sampled just before the next rise
      if (k - 1 >= rd && k - 1 < rd + 16) q[k - 1 - rd] = serial_out;
      #2;
      if (k <= n) begin
        shift_clock = 1'b1;
        #32;
        shift_clock = 1'b0;
      end
    end
    serial_in = ~serial_in; // no stale level after the frame
    chip_select = 1'b0;
    #900;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the serial nvram control block
`timescale 1ns/10ps
`include "snv_regs.svh"
module testbench;
  localparam int unsigned STORE_N = 2000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic save_pin_n = 1'b1, reload_pin_n = 1'b1, supply_low = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_out, serial_out_oe;
  logic chip_select, shift_clock, serial_in, store_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int err_count = 0;
  int n_compared = 0;
  snv_top #(.STORE_CYCLES(STORE_N)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .chip_select(chip_select), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .save_pin_n(save_pin_n),
    .reload_pin_n(reload_pin_n), .supply_low(supply_low), .store_busy(store_busy));
  snv_host_model host (.chip_select(chip_select), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  // 200 MHz system clock
  always #2.5 aclk = ~aclk;
  task automatic give_verdict;
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic timeout;
    err_count++;
    $display("MISMATCH %0t wait ran out", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bus masters hold each item until its own ready
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (t == 100) timeout();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t == 100) timeout();
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, e);
  endtask
  // serial instruction helpers
  task automatic cmd(input logic [2:0] op);
    logic [15:0] q;
    host.frame({1'b1, 4'h0, op, 24'h0}, 8, 99, q);
  endtask
  task automatic swr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic [15:0] b;
    b = {<<{d}};
    host.frame({1'b1, a, `SNV_OP_WRITE, b, 8'h00}, 24, 99, q);
  endtask
  task automatic srd(input logic [3:0] a, input logic x, input logic [15:0] e);
    logic [15:0] q;
    host.frame({1'b1, a, 2'b11, x, 24'h0}, 24, 8, q);
    chk({16'h0, q}, {16'h0, e});
    chk({31'h0, serial_out_oe}, 32'h0);
  endtask
  task automatic pins(input logic s, input logic r);
    @(posedge aclk);
    save_pin_n <= ~s;
    reload_pin_n <= ~r;
    repeat (4) @(posedge aclk);
    save_pin_n <= 1'b1;
    reload_pin_n <= 1'b1;
    repeat (10) @(posedge aclk);
  endtask
  task automatic wait_idle;
    int t;
    for (t = 0; t < 3000 && store_busy !== 1'b0; t++) @(posedge aclk);
    if (t == 3000) timeout();
  endtask
  task automatic t_locked;
    chk_rd(`SNV_STATUS_OFS, 32'h0);
    srd(4'h5, 1'b0, 16'h0);
    swr(4'h5, 16'hA5C3);
    srd(4'h5, 1'b0, 16'h0);
    cmd(`SNV_OP_SET_LATCH);
    chk_rd(`SNV_STATUS_OFS, 32'h1);
    swr(4'h5, 16'hA5C3);
    srd(4'h5, 1'b0, 16'h0);
    cmd(`SNV_OP_RELOAD);
    chk_rd(`SNV_STATUS_OFS, 32'h3);
  endtask
  task automatic t_rw;
    swr(4'h5, 16'hA5C3);
    srd(4'h5, 1'b0, 16'hA5C3);
    swr(4'hF, 16'h8001);
    srd(4'hF, 1'b1, 16'h8001);
    chk_rd(`SNV_RAM_BASE + 8'h14, 32'hA5C3);
    cmd(`SNV_OP_CLR_LATCH);
    chk_rd(`SNV_STATUS_OFS, 32'h2);
    swr(4'h5, 16'h1111);
    srd(4'h5, 1'b0, 16'hA5C3);
  endtask
  task automatic t_save;
    cmd(`SNV_OP_SET_LATCH);
    cmd(`SNV_OP_SAVE);
    chk({31'h0, store_busy}, 32'h1);
    swr(4'h5, 16'h2222);
    chk({31'h0, store_busy}, 32'h1);
    wait_idle();
    chk_rd(`SNV_STATUS_OFS, 32'h2);
    chk_rd(`SNV_NV_BASE + 8'h14, 32'hA5C3);
    srd(4'h5, 1'b0, 16'hA5C3);
    cmd(`SNV_OP_SAVE);
    chk({31'h0, store_busy}, 32'h0);
  endtask
  task automatic t_sleep;
    logic [31:0] d;
    logic [1:0] r;
    cmd(`SNV_OP_SLEEP);
    chk_rd(`SNV_STATUS_OFS, 32'hA);
    srd(4'h5, 1'b0, 16'h0);
    axi_wr(`SNV_CTRL_OFS, 32'h1, r);
    chk({30'h0, r}, 32'h0);
    chk_rd(`SNV_STATUS_OFS, 32'h0);
    chk_rd(`SNV_RAM_BASE + 8'h14, 32'hA5C3);
    cmd(`SNV_OP_SLEEP);
    pins(1'b0, 1'b1);
    chk_rd(`SNV_STATUS_OFS, 32'h2);
    srd(4'h5, 1'b0, 16'hA5C3);
    axi_wr(`SNV_STATUS_OFS, 32'h1, r);
    chk({30'h0, r}, {30'h0, `SNV_RESP_SLVERR});
    axi_rd(8'h08, d, r);
    chk({30'h0, r}, {30'h0, `SNV_RESP_DECERR});
  endtask
  task automatic t_frames;
    logic [15:0] q;
    host.frame({1'b1, 4'h0, `SNV_OP_SET_LATCH, 24'h0}, 5, 99, q);
    chk_rd(`SNV_STATUS_OFS, 32'h2);
    host.frame({2'b00, 1'b1, 4'h0, `SNV_OP_SET_LATCH, 22'h0}, 10, 99, q);
    chk_rd(`SNV_STATUS_OFS, 32'h3);
  endtask
  task automatic t_pins;
    @(posedge aclk);
    supply_low <= 1'b1;
    repeat (10) @(posedge aclk);
    chk_rd(`SNV_STATUS_OFS, 32'h12);
    pins(1'b1, 1'b0);
    chk({31'h0, store_busy}, 32'h0);
    supply_low <= 1'b0;
    repeat (10) @(posedge aclk);
    cmd(`SNV_OP_SET_LATCH);
    pins(1'b1, 1'b1);
    chk({31'h0, store_busy}, 32'h1);
    wait_idle();
    chk_rd(`SNV_STATUS_OFS, 32'h2);
  endtask
  // reset for three cycles, then the scenarios in order
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    t_locked();
    t_rw();
    t_save();
    t_sleep();
    t_frames();
    t_pins();
    give_verdict();
  end
  // overall limit on the run
  initial begin
    #400000;
    timeout();
  end
endmodule
